// ===== core/gcr_pkg.sv
// global control register bank: offsets, field layouts, reset values and shared types
package gcr_pkg;

	// word offsets
	localparam logic [23:0] OFS_ENABLES = 24'h000000;
	localparam logic [23:0] OFS_STATUS = 24'h000001;
	localparam logic [23:0] OFS_SYNTH = 24'h000002;
	localparam logic [23:0] OFS_RESETS_LO = 24'h000003;
	localparam logic [23:0] OFS_RESETS_HI = 24'h000004;
	localparam logic [23:0] OFS_ADDR_LO = 24'h000005;
	localparam logic [23:0] OFS_ADDR_HI = 24'h000006;
	localparam logic [23:0] OFS_IDENT = 24'h000007;
	localparam logic [23:0] OFS_SCRATCH = 24'h000008;
	localparam logic [23:0] OFS_CONTROL = 24'h000009;
	localparam logic [23:0] OFS_IRQ_MASK = 24'h00000a;
	localparam logic [23:0] OFS_IRQ_FLAGS = 24'h00000b;
	localparam logic [23:0] OFS_FRAME_CNT = 24'h00000c;

	// implemented-bit masks
	localparam logic [15:0] ENABLES_WMASK = 16'h7fff;
	localparam logic [15:0] ENABLES_FIXED = 16'h8000;
	localparam logic [15:0] SYNTH_WMASK = 16'h07ff;
	localparam logic [15:0] RESETS_LO_WMASK = 16'h7fff;
	localparam logic [15:0] RESETS_HI_WMASK = 16'h0007;
	localparam logic [15:0] ADDR_LO_WMASK = 16'hffdf;
	localparam logic [15:0] ADDR_HI_WMASK = 16'h03ff;
	localparam logic [15:0] CONTROL_WMASK = 16'h03ff;
	localparam logic [15:0] IRQ_WMASK = 16'h003f;

	// reset values
	localparam logic [15:0] ZERO_RST = 16'h0000;
	localparam logic [15:0] CONTROL_RST = 16'h0004;

	// interrupt flag positions
	localparam int IRQ_TICK = 0;
	localparam int IRQ_BOARD_PPS = 1;
	localparam int IRQ_FRAME = 2;
	localparam int IRQ_TEST_SUMS = 3;
	localparam int IRQ_SYS_PPS = 4;
	localparam int IRQ_PHASECAL = 5;

	// back-end operating modes
	typedef enum logic [1:0] {
		MODE_STATION_UNIT = 2'b00,
		MODE_VSI_OUTPUT = 2'b01,
		MODE_TV_GENERATE = 2'b10,
		MODE_TV_RECEIVE = 2'b11
	} gcr_mode_t;

	// pins toward the external clock synthesizer
	typedef struct packed {
		logic synth_load_clock;
		logic synth_reset_line;
		logic synth_update_strobe;
		logic [7:0] synth_serial_bits;
	} gcr_synth_t;

	// global board controls
	typedef struct packed {
		logic [1:0] led_b_colour;
		logic [1:0] led_a_colour;
		logic clock_source_onboard;
		logic spare_dav_n;
		logic spare_reset_n;
		logic refclk_oe_n;
		gcr_mode_t back_end_mode;
	} gcr_ctl_t;

	// buffer memory status levels from its own clock domain
	typedef struct packed {
		logic buffer_empty;
		logic [1:0] buffer_fill;
		logic init_done;
		logic clock_stopped;
		logic divided_clock_lock;
		logic board_clock_lock;
	} gcr_mem_status_t;

endpackage : gcr_pkg

// ===== core/gcr_global_regs.sv
// global control register bank of the data output board, host side word access
`timescale 1ns/1ns
module gcr_global_regs #(
	parameter logic [7:0] ID_CODE = 8'ha7, // arbitrary value
	parameter logic INPUT_VARIANT = 1'b0,
	parameter logic HAS_PHASECAL = 1'b0,
	parameter logic [5:0] REVISION = 6'h01
) (
	input wire logic clock,
	input wire logic sys_rst,
	// host access, one strobe per access
	input wire logic [24:0] host_addr,
	input wire logic host_wr,
	input wire logic host_rd,
	input wire logic [15:0] host_wdata,
	output logic [15:0] host_rdata_r,
	output logic host_ack_r,
	output logic host_irq_r,
	// events from subblocks on this clock
	input wire logic header_error_evt,
	input wire logic tick_evt,
	input wire logic board_pps_evt,
	input wire logic frame_evt,
	input wire logic test_sums_evt,
	input wire logic system_pps_evt,
	input wire logic phasecal_evt,
	input wire logic vsi_delay_change_evt,
	// levels from the buffer memory domain
	input wire gcr_pkg::gcr_mem_status_t mem_status_async,
	// outputs to the board
	output logic [14:0] block_enable_r,
	output logic [14:0] block_reset_low_r,
	output logic [2:0] block_reset_high_r,
	output gcr_pkg::gcr_synth_t synth_r,
	output gcr_pkg::gcr_ctl_t ctl_r,
	output logic [25:0] buffer_start_addr_r
);
	import gcr_pkg::*;

	////////////////////////////////////////////////////////////////////////////
	// decode

	logic [23:0] word_ofs;
	logic wr_enables;
	logic wr_synth;
	logic wr_resets_lo;
	logic wr_resets_hi;
	logic wr_addr_lo;
	logic wr_addr_hi;
	logic wr_scratch;
	logic wr_control;
	logic wr_irq_mask;
	logic rd_irq_flags;

	// lowest byte-address bit is dropped, two host bytes per word
	assign word_ofs = host_addr[24:1];
	assign wr_enables = host_wr && (word_ofs == OFS_ENABLES);
	assign wr_synth = host_wr && (word_ofs == OFS_SYNTH);
	assign wr_resets_lo = host_wr && (word_ofs == OFS_RESETS_LO);
	assign wr_resets_hi = host_wr && (word_ofs == OFS_RESETS_HI);
	assign wr_addr_lo = host_wr && (word_ofs == OFS_ADDR_LO);
	assign wr_addr_hi = host_wr && (word_ofs == OFS_ADDR_HI);
	assign wr_scratch = host_wr && (word_ofs == OFS_SCRATCH);
	assign wr_control = host_wr && (word_ofs == OFS_CONTROL);
	assign wr_irq_mask = host_wr && (word_ofs == OFS_IRQ_MASK);
	assign rd_irq_flags = host_rd && (word_ofs == OFS_IRQ_FLAGS);

	////////////////////////////////////////////////////////////////////////////
	// status synchroniser, the memory clock is foreign to this domain

	gcr_mem_status_t mem_meta_r;
	gcr_mem_status_t mem_sync_r;

	// first stage is only read by the second stage
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			mem_meta_r <= '0;
			mem_sync_r <= '0;
		end else begin
			mem_meta_r <= mem_status_async;
			mem_sync_r <= mem_meta_r;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// software-written registers

	logic [15:0] enables_r, enables_nxt;
	logic [15:0] synth_word_r, synth_word_nxt;
	logic [15:0] resets_lo_r, resets_lo_nxt;
	logic [15:0] resets_hi_r, resets_hi_nxt;
	logic [15:0] addr_lo_r, addr_lo_nxt;
	logic [15:0] addr_hi_r, addr_hi_nxt;
	logic [15:0] scratch_r, scratch_nxt;
	logic [15:0] control_r, control_nxt;
	logic [15:0] irq_mask_r, irq_mask_nxt;

	// unimplemented bits are masked off so they never store
	always_comb begin
		enables_nxt = enables_r;
		synth_word_nxt = synth_word_r;
		resets_lo_nxt = resets_lo_r;
		resets_hi_nxt = resets_hi_r;
		addr_lo_nxt = addr_lo_r;
		addr_hi_nxt = addr_hi_r;
		scratch_nxt = scratch_r;
		control_nxt = control_r;
		irq_mask_nxt = irq_mask_r;
		if (wr_enables) begin
			enables_nxt = host_wdata & ENABLES_WMASK;
		end
		if (wr_synth) begin
			synth_word_nxt = host_wdata & SYNTH_WMASK;
		end
		if (wr_resets_lo) begin
			resets_lo_nxt = host_wdata & RESETS_LO_WMASK;
		end
		if (wr_resets_hi) begin
			resets_hi_nxt = host_wdata & RESETS_HI_WMASK;
		end
		if (wr_addr_lo) begin
			addr_lo_nxt = host_wdata & ADDR_LO_WMASK;
		end
		if (wr_addr_hi) begin
			addr_hi_nxt = host_wdata & ADDR_HI_WMASK;
		end
		if (wr_scratch) begin
			scratch_nxt = host_wdata;
		end
		if (wr_control) begin
			// all four mode codes are defined, so no code is refused
			control_nxt = host_wdata & CONTROL_WMASK;
		end
		if (wr_irq_mask) begin
			irq_mask_nxt = host_wdata & IRQ_WMASK;
		end
	end

	// control keeps the reference clock tristated out of reset
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			enables_r <= ZERO_RST;
			synth_word_r <= ZERO_RST;
			resets_lo_r <= ZERO_RST;
			resets_hi_r <= ZERO_RST;
			addr_lo_r <= ZERO_RST;
			addr_hi_r <= ZERO_RST;
			scratch_r <= ZERO_RST;
			control_r <= CONTROL_RST;
			irq_mask_r <= ZERO_RST;
		end else begin
			enables_r <= enables_nxt;
			synth_word_r <= synth_word_nxt;
			resets_lo_r <= resets_lo_nxt;
			resets_hi_r <= resets_hi_nxt;
			addr_lo_r <= addr_lo_nxt;
			addr_hi_r <= addr_hi_nxt;
			scratch_r <= scratch_nxt;
			control_r <= control_nxt;
			irq_mask_r <= irq_mask_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// board outputs, each loaded from its register's next value on the same edge as the register

	logic [14:0] block_enable_nxt;
	logic [14:0] block_reset_low_nxt;
	logic [2:0] block_reset_high_nxt;
	gcr_synth_t synth_nxt;
	gcr_ctl_t ctl_nxt;

	// extra flop stage keeps every port straight off a flip-flop
	always_comb begin
		block_enable_nxt = enables_nxt[14:0];
		block_reset_low_nxt = resets_lo_nxt[14:0];
		block_reset_high_nxt = resets_hi_nxt[2:0];
		synth_nxt.synth_serial_bits = synth_word_nxt[7:0];
		synth_nxt.synth_update_strobe = synth_word_nxt[8];
		synth_nxt.synth_reset_line = synth_word_nxt[9];
		synth_nxt.synth_load_clock = synth_word_nxt[10];
		ctl_nxt.back_end_mode = gcr_mode_t'(control_nxt[1:0]);
		ctl_nxt.refclk_oe_n = control_nxt[2];
		ctl_nxt.spare_dav_n = control_nxt[3];
		ctl_nxt.spare_reset_n = control_nxt[4];
		ctl_nxt.clock_source_onboard = control_nxt[5];
		ctl_nxt.led_a_colour = control_nxt[7:6];
		ctl_nxt.led_b_colour = control_nxt[9:8];
	end

	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			block_enable_r <= '0;
			block_reset_low_r <= '0;
			block_reset_high_r <= '0;
			synth_r <= '0;
			ctl_r <= gcr_ctl_t'(CONTROL_RST[9:0]);
		end else begin
			block_enable_r <= block_enable_nxt;
			block_reset_low_r <= block_reset_low_nxt;
			block_reset_high_r <= block_reset_high_nxt;
			synth_r <= synth_nxt;
			ctl_r <= ctl_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// start read address, staged until the next frame or delay change

	logic [25:0] start_addr_nxt;
	logic [25:0] staged_addr;

	// bit 5 has no storage and stays zero in the assembled address
	assign staged_addr = {addr_hi_r[9:0], addr_lo_r[15:6], 1'b0, addr_lo_r[4:0]};

	// a write in the boundary cycle misses it and waits for the next one
	always_comb begin
		start_addr_nxt = buffer_start_addr_r;
		if (frame_evt || vsi_delay_change_evt) begin
			start_addr_nxt = staged_addr;
		end
	end

	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			buffer_start_addr_r <= '0;
		end else begin
			buffer_start_addr_r <= start_addr_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// sticky header error, frame counter, interrupt flags and line

	logic header_err_r, header_err_nxt;
	logic [15:0] frame_cnt_r, frame_cnt_nxt;
	logic [5:0] irq_flags_r, irq_flags_nxt;
	logic [5:0] irq_events;
	logic host_irq_nxt;

	assign irq_events[IRQ_TICK] = tick_evt;
	assign irq_events[IRQ_BOARD_PPS] = board_pps_evt;
	assign irq_events[IRQ_FRAME] = frame_evt;
	assign irq_events[IRQ_TEST_SUMS] = test_sums_evt;
	assign irq_events[IRQ_SYS_PPS] = system_pps_evt;
	assign irq_events[IRQ_PHASECAL] = phasecal_evt;

	// an event in the read cycle survives the clear, so none is lost
	always_comb begin
		header_err_nxt = header_err_r | header_error_evt;
		frame_cnt_nxt = frame_cnt_r;
		if (frame_evt) begin
			frame_cnt_nxt = frame_cnt_r + 16'h0001;
		end
		irq_flags_nxt = irq_flags_r;
		if (rd_irq_flags) begin
			irq_flags_nxt = '0;
		end
		irq_flags_nxt = irq_flags_nxt | irq_events;
		host_irq_nxt = |(irq_flags_nxt & irq_mask_nxt[5:0]);
	end

	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			header_err_r <= 1'b0;
			frame_cnt_r <= '0;
			irq_flags_r <= '0;
			host_irq_r <= 1'b0;
		end else begin
			header_err_r <= header_err_nxt;
			frame_cnt_r <= frame_cnt_nxt;
			irq_flags_r <= irq_flags_nxt;
			host_irq_r <= host_irq_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// read mux, answered one cycle after the strobe

	logic [15:0] status_word;
	logic [15:0] ident_word;
	logic [15:0] rdata_nxt;
	logic ack_nxt;

	// unused status bits are tied low
	assign status_word = {4'h0, mem_sync_r.buffer_empty, mem_sync_r.buffer_fill,
		mem_sync_r.init_done, 4'h0, mem_sync_r.clock_stopped,
		mem_sync_r.divided_clock_lock, mem_sync_r.board_clock_lock, header_err_r};
	assign ident_word = {ID_CODE, INPUT_VARIANT, HAS_PHASECAL, REVISION};

	// unmapped offsets read as zero
	always_comb begin
		rdata_nxt = '0;
		ack_nxt = host_rd || host_wr;
		if (host_rd) begin
			unique case (word_ofs)
				OFS_ENABLES: rdata_nxt = enables_r | ENABLES_FIXED;
				OFS_STATUS: rdata_nxt = status_word;
				OFS_SYNTH: rdata_nxt = synth_word_r;
				OFS_RESETS_LO: rdata_nxt = resets_lo_r;
				OFS_RESETS_HI: rdata_nxt = resets_hi_r;
				OFS_ADDR_LO: rdata_nxt = addr_lo_r;
				OFS_ADDR_HI: rdata_nxt = addr_hi_r;
				OFS_IDENT: rdata_nxt = ident_word;
				OFS_SCRATCH: rdata_nxt = scratch_r;
				OFS_CONTROL: rdata_nxt = control_r;
				OFS_IRQ_MASK: rdata_nxt = irq_mask_r;
				OFS_IRQ_FLAGS: rdata_nxt = {10'h000, irq_flags_r};
				OFS_FRAME_CNT: rdata_nxt = frame_cnt_r;
				default: rdata_nxt = '0;
			endcase
		end
	end

	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			host_rdata_r <= '0;
			host_ack_r <= 1'b0;
		end else begin
			host_rdata_r <= rdata_nxt;
			host_ack_r <= ack_nxt;
		end
	end

endmodule : gcr_global_regs

// ===== tb/gcr_regs_sva.sv
// assertion checker for the global control register bank ports
`timescale 1ns/1ns
module gcr_regs_sva #(
	parameter logic [7:0] ID_CODE = 8'ha7, // arbitrary value
	parameter logic INPUT_VARIANT = 1'b0,
	parameter logic HAS_PHASECAL = 1'b0,
	parameter logic [5:0] REVISION = 6'h01
) (
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic [24:0] host_addr,
	input wire logic host_wr,
	input wire logic host_rd,
	input wire logic [15:0] host_wdata,
	input wire logic [15:0] host_rdata_r,
	input wire logic host_ack_r,
	input wire logic host_irq_r,
	input wire logic header_error_evt,
	input wire logic tick_evt,
	input wire logic board_pps_evt,
	input wire logic frame_evt,
	input wire logic test_sums_evt,
	input wire logic system_pps_evt,
	input wire logic phasecal_evt,
	input wire logic vsi_delay_change_evt,
	input wire gcr_pkg::gcr_mem_status_t mem_status_async,
	input wire logic [14:0] block_enable_r,
	input wire logic [14:0] block_reset_low_r,
	input wire logic [2:0] block_reset_high_r,
	input wire gcr_pkg::gcr_synth_t synth_r,
	input wire gcr_pkg::gcr_ctl_t ctl_r,
	input wire logic [25:0] buffer_start_addr_r
);
	import gcr_pkg::*;
	default clocking cb @(posedge clock); endclocking
	default disable iff (sys_rst);
	wire logic [23:0] wofs = host_addr[24:1];
	wire logic any_irq_evt = tick_evt | board_pps_evt | frame_evt | test_sums_evt | system_pps_evt | phasecal_evt;
	logic hdr_seen_r;
	logic hdr_seen_nxt;
	////////////////////////////////////////////////////////////////////////////////
	// shadow of the sticky header error, only reset may clear it
	always_comb begin
		hdr_seen_nxt = hdr_seen_r | header_error_evt;
	end
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			hdr_seen_r <= 1'b0;
		end else begin
			hdr_seen_r <= hdr_seen_nxt;
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	// register outputs against host writes and reads
	enable_copy_a: assert property (
		host_wr && wofs == OFS_ENABLES |=> block_enable_r == $past(host_wdata[14:0]))
		else $error("enable outputs do not follow the write");
	enable_top_a: assert property (
		host_rd && wofs == OFS_ENABLES |=> host_rdata_r[15])
		else $error("enable bit 15 read as zero");
	reset_low_a: assert property (
		host_wr && wofs == OFS_RESETS_LO |=> block_reset_low_r == $past(host_wdata[14:0]))
		else $error("low reset outputs do not follow the write");
	reset_high_a: assert property (
		host_wr && wofs == OFS_RESETS_HI |=> block_reset_high_r == $past(host_wdata[2:0]))
		else $error("high reset outputs do not follow the write");
	synth_copy_a: assert property (
		host_wr && wofs == OFS_SYNTH |=> synth_r == $past(host_wdata[10:0]))
		else $error("synthesizer pins do not follow the write");
	status_zero_a: assert property (
		host_rd && wofs == OFS_STATUS |=> (host_rdata_r & 16'hf0f0) == 16'h0000)
		else $error("status spare bits not zero");
	header_sticky_a: assert property (
		host_rd && wofs == OFS_STATUS |=> host_rdata_r[0] == $past(hdr_seen_r))
		else $error("header error bit wrong");
	ident_value_a: assert property (
		host_rd && wofs == OFS_IDENT |=> host_rdata_r == {ID_CODE, INPUT_VARIANT, HAS_PHASECAL, REVISION})
		else $error("identification word wrong");
	flags_clear_a: assert property (
		host_rd && wofs == OFS_IRQ_FLAGS && !any_irq_evt |=> !host_irq_r)
		else $error("interrupt still raised after flag read");
	start_hold_a: assert property (
		!(frame_evt || vsi_delay_change_evt) |=> $stable(buffer_start_addr_r))
		else $error("start address moved without a boundary");
	reset_vals_a: assert property (
		$fell(sys_rst) |-> ctl_r == CONTROL_RST[9:0] && block_enable_r == 15'h0000 && buffer_start_addr_r == 26'h0)
		else $error("outputs not at reset values");
	cover property (frame_evt && host_irq_r == 1'b0);
	cover property (host_rd && wofs == OFS_IRQ_FLAGS);
	cover property (header_error_evt);
endmodule : gcr_regs_sva

bind gcr_global_regs gcr_regs_sva #(.ID_CODE(ID_CODE), .INPUT_VARIANT(INPUT_VARIANT),
	.HAS_PHASECAL(HAS_PHASECAL), .REVISION(REVISION)) gcr_regs_sva_inst (.clock(clock), .sys_rst(sys_rst),
	.host_addr(host_addr), .host_wr(host_wr), .host_rd(host_rd), .host_wdata(host_wdata),
	.host_rdata_r(host_rdata_r), .host_ack_r(host_ack_r), .host_irq_r(host_irq_r),
	.header_error_evt(header_error_evt), .tick_evt(tick_evt), .board_pps_evt(board_pps_evt),
	.frame_evt(frame_evt), .test_sums_evt(test_sums_evt), .system_pps_evt(system_pps_evt),
	.phasecal_evt(phasecal_evt), .vsi_delay_change_evt(vsi_delay_change_evt),
	.mem_status_async(mem_status_async), .block_enable_r(block_enable_r),
	.block_reset_low_r(block_reset_low_r), .block_reset_high_r(block_reset_high_r),
	.synth_r(synth_r), .ctl_r(ctl_r), .buffer_start_addr_r(buffer_start_addr_r));

// ===== tb/gcr_host_model.sv
// host model: strobe bus master standing in for driver software
`timescale 1ns/1ns
module gcr_host_model (
	input wire logic clock,
	output logic [24:0] host_addr,
	output logic host_wr,
	output logic host_rd,
	output logic [15:0] host_wdata,
	input wire logic [15:0] host_rdata_r,
	input wire logic host_ack_r
);
	// idle bus at time zero
	initial begin
		host_addr = 25'h0000000;
		host_wr = 1'b0;
		host_rd = 1'b0;
		host_wdata = 16'h0000;
	end
	////////////////////////////////////////////////////////////////////////////////
	// one access, answer taken in the cycle the ack stands; released lines show the
	// inverse so a stale address or data word can never pass for a live one
	task automatic access(input logic wr, input logic [24:0] a, input logic [15:0] d, output logic [16:0] ans);
		@(negedge clock);
		host_addr = a;
		host_wdata = d;
		host_wr = wr;
		host_rd = !wr;
		@(negedge clock);
		ans = {host_ack_r, host_rdata_r};
		host_wr = 1'b0;
		host_rd = 1'b0;
		host_addr = ~a;
		host_wdata = ~d;
	endtask : access
endmodule : gcr_host_model

// ===== tb/gcr_global_regs_tb.sv
// self-checking bench for the global control register bank
`timescale 1ns/1ns
module gcr_global_regs_tb;
	import gcr_pkg::*;
	localparam logic [7:0] ID = 8'h3c; // arbitrary value
	logic clock = 1'b0;
	logic sys_rst = 1'b1;
	logic [24:0] host_addr;
	logic host_wr;
	logic host_rd;
	logic [15:0] host_wdata;
	logic [15:0] host_rdata_r;
	logic host_ack_r;
	logic host_irq_r;
	logic [7:0] ev = 8'h00;
	gcr_mem_status_t mem_st = '0;
	logic [14:0] en_o;
	logic [14:0] rlo_o;
	logic [2:0] rhi_o;
	gcr_synth_t synth_o;
	gcr_ctl_t ctl_o;
	logic [25:0] start_o;
	logic [16:0] ans;
	int mismatches = 0;
	int num_checks = 0;
	logic [15:0] rst_tab [0:13] = '{16'h8000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
		{ID, 8'h01}, 16'h0000, 16'h0004, 16'h0000, 16'h0000, 16'h0000, 16'h0000};
	logic [15:0] rw_tab [0:13] = '{16'hffff, 16'h0000, 16'h07ff, 16'h7fff, 16'h0007, 16'hffdf, 16'h03ff,
		{ID, 8'h01}, 16'hffff, 16'h03ff, 16'h003f, 16'h0000, 16'h0000, 16'h0000};
	always #5 clock = ~clock;
	gcr_global_regs #(.ID_CODE(ID)) gcr_global_regs_inst (.clock(clock), .sys_rst(sys_rst),
		.host_addr(host_addr), .host_wr(host_wr), .host_rd(host_rd), .host_wdata(host_wdata),
		.host_rdata_r(host_rdata_r), .host_ack_r(host_ack_r), .host_irq_r(host_irq_r),
		.header_error_evt(ev[6]), .tick_evt(ev[0]), .board_pps_evt(ev[1]), .frame_evt(ev[2]),
		.test_sums_evt(ev[3]), .system_pps_evt(ev[4]), .phasecal_evt(ev[5]), .vsi_delay_change_evt(ev[7]),
		.mem_status_async(mem_st), .block_enable_r(en_o), .block_reset_low_r(rlo_o),
		.block_reset_high_r(rhi_o), .synth_r(synth_o), .ctl_r(ctl_o), .buffer_start_addr_r(start_o));
	gcr_host_model gcr_host_model_inst (.clock(clock), .host_addr(host_addr), .host_wr(host_wr),
		.host_rd(host_rd), .host_wdata(host_wdata), .host_rdata_r(host_rdata_r), .host_ack_r(host_ack_r));
	////////////////////////////////////////////////////////////////////////////////
	// shared comparison and bus helpers
	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		num_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("unexpected %s: expected %h seen %h", what, exp, got);
		end
	endtask : check
	// writes go to the odd byte of the word, so the dropped address bit is exercised
	task automatic wr(input logic [23:0] o, input logic [15:0] d);
		gcr_host_model_inst.access(1'b1, {o, 1'b1}, d, ans);
	endtask : wr
	task automatic rdc(input string n, input logic [23:0] o, input logic [15:0] e);
		gcr_host_model_inst.access(1'b0, {o, 1'b0}, 16'h0000, ans);
		check("read ack", 32'h1, {31'h0, ans[16]});
		check(n, {16'h0, e}, {16'h0, ans[15:0]});
	endtask : rdc
	task automatic pulse(input logic [7:0] p);
		@(negedge clock);
		ev = p;
		@(negedge clock);
		ev = 8'h00;
	endtask : pulse
	////////////////////////////////////////////////////////////////////////////////
	// scenarios
	task automatic t_reset;
		for (int i = 0; i < 14; i++) rdc("reset value", 24'(i), rst_tab[i]);
		check("control pins", 32'h004, {22'h0, ctl_o});
	endtask : t_reset
	// all ones everywhere; read-only words, spare bits and the unmapped word keep nothing
	task automatic t_rw;
		for (int i = 0; i < 14; i++) wr(24'(i), 16'hffff);
		for (int i = 0; i < 14; i++) rdc("written value", 24'(i), rw_tab[i]);
		check("enables", 32'h7fff, {17'h0, en_o});
		check("resets low", 32'h7fff, {17'h0, rlo_o});
		check("resets high", 32'h7, {29'h0, rhi_o});
		check("synth pins", 32'h7ff, {21'h0, synth_o});
		check("start address", 32'h0, {6'h0, start_o});
		wr(OFS_SCRATCH, 16'ha5c3);
		rdc("scratch", OFS_SCRATCH, 16'ha5c3);
	endtask : t_rw
	// every mode and colour code, clock source, tristate and the two spare pins
	task automatic t_ctl;
		logic [1:0] m;
		for (int i = 0; i < 4; i++) begin
			m = 2'(i);
			wr(OFS_CONTROL, {6'h00, m, m, m[0], 2'b01, m[1], m});
			check("control pins", {22'h0, m, m, m[0], 2'b10, m[1], m}, {22'h0, ctl_o});
			rdc("control", OFS_CONTROL, {6'h00, m, m, m[0], 2'b01, m[1], m});
		end
	endtask : t_ctl
	task automatic t_status;
		mem_st = 7'b1010101;
		repeat (4) @(negedge clock);
		rdc("status", OFS_STATUS, 16'h0a0a);
		mem_st = 7'b0101010;
		repeat (4) @(negedge clock);
		rdc("status", OFS_STATUS, 16'h0504);
		pulse(8'h40);
		mem_st = '0;
		repeat (4) @(negedge clock);
		rdc("status", OFS_STATUS, 16'h0001);
		rdc("status", OFS_STATUS, 16'h0001);
	endtask : t_status
	// each source sets its own flag; a read clears; only masked-in flags raise the line
	task automatic t_irq;
		wr(OFS_IRQ_MASK, 16'h0000);
		for (int i = 0; i < 6; i++) begin
			pulse(8'h01 << i);
			check("irq line", 32'h0, {31'h0, host_irq_r});
			rdc("flags", OFS_IRQ_FLAGS, 16'h0001 << i);
			rdc("flags", OFS_IRQ_FLAGS, 16'h0000);
		end
		wr(OFS_IRQ_MASK, 16'h0004);
		pulse(8'h01);
		check("irq line", 32'h0, {31'h0, host_irq_r});
		pulse(8'h04);
		check("irq line", 32'h1, {31'h0, host_irq_r});
		rdc("flags", OFS_IRQ_FLAGS, 16'h0005);
		check("irq line", 32'h0, {31'h0, host_irq_r});
	endtask : t_irq
	task automatic t_frame;
		check("start address", 32'h3ffffdf, {6'h0, start_o});
		wr(OFS_ADDR_LO, 16'h1234);
		wr(OFS_ADDR_HI, 16'hff55);
		check("start address", 32'h3ffffdf, {6'h0, start_o});
		pulse(8'h80);
		check("start address", 32'h3551214, {6'h0, start_o});
		wr(OFS_ADDR_LO, 16'h0000);
		wr(OFS_ADDR_HI, 16'h0000);
		pulse(8'h04);
		check("start address", 32'h0, {6'h0, start_o});
		rdc("frame count", OFS_FRAME_CNT, 16'h0003);
	endtask : t_frame
	// board reset in mid-run: the sticky header error and the raised line go, control returns to its reset word
	task automatic t_rerst;
		@(negedge clock);
		sys_rst = 1'b1;
		repeat (2) @(negedge clock);
		sys_rst = 1'b0;
		check("irq line", 32'h0, {31'h0, host_irq_r});
		check("start address", 32'h0, {6'h0, start_o});
		rdc("status", OFS_STATUS, 16'h0000);
		rdc("control", OFS_CONTROL, 16'h0004);
		rdc("flags", OFS_IRQ_FLAGS, 16'h0000);
	endtask : t_rerst
	////////////////////////////////////////////////////////////////////////////////
	// verdict and end of run
	task automatic finish_test;
		if (mismatches == 0 && num_checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : finish_test
	// the whole run needs a few hundred cycles; 20000 leaves wide margin
	initial begin
		#200000;
		mismatches++;
		finish_test;
	end
	initial begin
		repeat (5) @(posedge clock);
		@(negedge clock);
		sys_rst = 1'b0;
		t_reset;
		t_rw;
		t_ctl;
		t_status;
		t_irq;
		t_frame;
		t_rerst;
		finish_test;
	end
endmodule : gcr_global_regs_tb
